// ===== logic/ldi_pkg.sv
package ldi_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int SELF_CLEAR_MS = 8;
  localparam int SELF_CLEAR_CYCLES = CLK_HZ / 1000 * SELF_CLEAR_MS;

  // ----------------------------------------------------------------------
  // Target address
  // ----------------------------------------------------------------------
  localparam logic [2:0] TARGET_ADDR_FIXED = 3'h5;
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_SCL = 2'h1;
  localparam logic [1:0] STRAP_SDA = 2'h2;
  localparam logic [1:0] STRAP_SUPPLY = 2'h3;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ----------------------------------------------------------------------
  // Register offsets and values
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_INTERRUPT_ENABLE_MASK = 8'hF0;
  localparam logic [7:0] REG_INTERRUPT_FLAGS = 8'hF1;
  localparam logic [7:0] REG_PAGE_SELECT = 8'hFD;
  localparam logic [7:0] REG_PAGE_SELECT_UNLOCK = 8'hFE;
  localparam logic [7:0] PAGE_UNLOCK_KEY = 8'hC5;
  localparam logic [7:0] UNLOCK_RESET = 8'h00;
  localparam logic [7:0] PAGE_LAST_VALUE = 8'h03;
  localparam logic [1:0] PAGE_RESET = 2'h0;
  localparam logic [1:0] LED_CONTROL_PAGE = 2'h0;
  localparam logic [1:0] FUNCTION_PAGE = 2'h3;
  localparam logic [7:0] LED_READ_FIRST = 8'h18;
  localparam logic [7:0] LED_READ_LAST = 8'h47;
  localparam logic [7:0] FUNCTION_READ_ADDR = 8'h11;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Mask and flag fields
  // ----------------------------------------------------------------------
  localparam int MASK_IRQ_SELF_CLEAR_EN = 3;
  localparam int MASK_BREATH_DONE_IRQ_EN = 2;
  localparam int MASK_SHORT_IRQ_EN = 1;
  localparam int MASK_OPEN_IRQ_EN = 0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [4:0] FLAGS_RESET = 5'h00;

  // Bit order matches the flag register, D4 down to D0.
  typedef struct packed {
    logic breath_pattern_three_done;
    logic breath_pattern_two_done;
    logic breath_pattern_one_done;
    logic short_seen_flag;
    logic open_seen_flag;
  } ldi_flags_s;

  typedef struct packed {
    logic [1:0] page;
    logic [7:0] addr;
    logic [7:0] data;
  } ldi_page_wr_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_REG = 4'h3,
    ST_REG_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_READ = 4'h7,
    ST_READ_ACK = 4'h8
  } ldi_state_e;

endpackage : ldi_pkg

// ===== logic/ldi_sync.sv
`timescale 1ns/1ps
module ldi_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,              // Destination clock.
  input wire logic reset,              // Synchronous reset, active high.
  input wire logic [WIDTH-1:0] async_in, // Levels from another domain.
  output logic [WIDTH-1:0] sync_out    // Settled levels.
);

  // ----------------------------------------------------------------------
  // Three stages per bit; output moves once stages two and three agree.
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic [2:0] stage;
    logic agreed;
    always_ff @(posedge clock) begin
      if (reset) begin
        stage <= 3'h0;
        agreed <= 1'b0;
      end else begin
        stage <= {stage[1:0], async_in[i]};
        if (stage[1] == stage[2]) begin
          agreed <= stage[2];
        end
      end
    end
    assign sync_out[i] = agreed;
  end

endmodule : ldi_sync

// ===== logic/ldi_i2c_port.sv
`timescale 1ns/1ps
// Overview of operation
// [R01] Answer address 101, strap pair bits below.
// [R02] Strap tie GND/SCL/SDA/supply gives 00/01/10/11.
// [R03] Eighth address bit: 0 write, 1 read.
// [R04] Sample SDA while SCL high.
// [R05] Controller keeps SDA high when idle.
// [R06] Detect start and stop; restart matching.
// [R07] Pull SDA low on matching address acknowledge.
// [R08] Controller stops on missing address acknowledge.
// [R09] First written byte is register address, acknowledged.
// [R10] Acknowledge every received data byte.
// [R11] Pointer increments during each data acknowledge.
// [R12] Only lock, flags, paged read locations readable.
// [R13] Read: write address, repeated start, read.
// [R14] Controller selects page 0 or 3 first.
// [R15] Page values 0 to 3, reset zero.
// [R16] Page writes routed to selected page.
// [R17] Page register locked, writes ignored when locked.
// [R18] Key C5 allows one page write, then clears.
// [R19] Mask D3 enables 8 ms interrupt self-clear.
// [R20] Mask D2..D0 enable breath, short, open.
// [R21] Flags D4..D0: breath 3..1, short, open.
// [R22] Interrupt low while any enabled flag set.
module ldi_i2c_port #(
  parameter int SELF_CLEAR_CYCLES = ldi_pkg::SELF_CLEAR_CYCLES
) (
  input wire logic clock,                   // Core clock, 40 MHz.
  input wire logic reset,                   // Synchronous reset, high.
  input wire logic link_clock,              // Link sampling clock.
  input wire logic scl,                     // Serial clock pin.
  input wire logic sda_in,                  // Serial data pin level.
  output logic sda_out,                     // Serial data drive value.
  output logic sda_oe,                      // Serial data drive enable.
  input wire logic addr_strap_low_pair,     // Strap for address bits 2:1.
  input wire logic addr_strap_high_pair,    // Strap for address bits 4:3.
  input wire ldi_pkg::ldi_flags_s events,   // Flag set pulses, core clock.
  output logic irq_out_n,                   // Interrupt, active low.
  output logic page_wr_valid,               // Paged write pulse, link clock.
  output ldi_pkg::ldi_page_wr_s page_wr,    // Paged write page/addr/data.
  output logic [1:0] page_rd_page,          // Selected page for reads.
  output logic [7:0] page_rd_addr,          // Paged read address.
  input wire logic [7:0] page_rd_data       // Paged read data, link clock.
);

  // ----------------------------------------------------------------------
  // Link domain reset and pin synchronisation
  // ----------------------------------------------------------------------
  logic [1:0] link_rst_meta;
  logic link_reset;
  logic [3:0] pins_s;
  logic scl_s, sda_s, strap_lo_s, strap_hi_s;
  logic scl_d, sda_d, strap_lo_d, strap_hi_d;
  logic start_seen, stop_seen, scl_rise, scl_fall;

  always_ff @(posedge link_clock) begin
    {link_reset, link_rst_meta} <= {link_rst_meta, reset};
  end

  ldi_sync #(.WIDTH(4)) u_pin_sync (
    .clock(link_clock),
    .reset(link_reset),
    .async_in({addr_strap_high_pair, addr_strap_low_pair, sda_in, scl}),
    .sync_out(pins_s)
  );

  assign {strap_hi_s, strap_lo_s, sda_s, scl_s} = pins_s;

  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      {strap_hi_d, strap_lo_d, sda_d, scl_d} <= 4'h0;
    end else begin
      {strap_hi_d, strap_lo_d, sda_d, scl_d} <= pins_s;
    end
  end

  assign start_seen = scl_s & scl_d & sda_d & ~sda_s; // [R06]
  assign stop_seen = scl_s & scl_d & ~sda_d & sda_s; // [R06]
  assign scl_rise = scl_s & ~scl_d; // [R04]
  assign scl_fall = ~scl_s & scl_d;
  assign sda_out = 1'b0;

  // ----------------------------------------------------------------------
  // Strap decoding
  // ----------------------------------------------------------------------
  // A strap is sampled in idle, at the start and at the first SCL fall,
  // which tells a fixed level apart from a strap tied to SCL or SDA.
  logic [1:0] strap_idle, strap_start, strap_fall;
  logic fall_pending;
  logic [1:0] code_lo, code_hi;
  logic [6:0] own_addr;

  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      {strap_idle, strap_start, strap_fall} <= 6'h00;
      fall_pending <= 1'b0;
    end else if (start_seen) begin
      strap_idle <= {strap_hi_d, strap_lo_d};
      strap_start <= {strap_hi_s, strap_lo_s};
      fall_pending <= 1'b1;
    end else if (scl_fall && fall_pending) begin
      strap_fall <= {strap_hi_s, strap_lo_s};
      fall_pending <= 1'b0;
    end
  end

  function automatic logic [1:0] strap_code(input logic idle_lvl,
                                            input logic start_lvl,
                                            input logic fall_lvl);
    return start_lvl ? (fall_lvl ? ldi_pkg::STRAP_SUPPLY
                                 : ldi_pkg::STRAP_SCL)
                     : (idle_lvl ? ldi_pkg::STRAP_SDA
                                 : ldi_pkg::STRAP_GND); // [R02]
  endfunction : strap_code

  assign code_lo = strap_code(strap_idle[0], strap_start[0], strap_fall[0]);
  assign code_hi = strap_code(strap_idle[1], strap_start[1], strap_fall[1]);
  assign own_addr = {ldi_pkg::TARGET_ADDR_FIXED, code_hi, code_lo}; // [R01]

  // ----------------------------------------------------------------------
  // Transfer state machine
  // ----------------------------------------------------------------------
  ldi_pkg::ldi_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg, tx_byte, rd_byte, reg_ptr, unlock;
  logic read_dir, master_ack, byte_end, data_taken, tx_load, clear_tgl;
  logic [1:0] page;
  logic [3:0] mask_l;
  logic [4:0] flags_l;

  assign byte_end = scl_fall && (bit_cnt == ldi_pkg::BYTE_BITS);
  assign data_taken = byte_end && (state == ldi_pkg::ST_WDATA);
  assign tx_load = scl_fall && ((state == ldi_pkg::ST_ADDR_ACK && read_dir)
                   || (state == ldi_pkg::ST_READ_ACK && master_ack));

  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      state <= ldi_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      {shreg, tx_byte} <= 16'h0000;
      {read_dir, master_ack, sda_oe} <= 3'h0;
    end else if (start_seen) begin
      state <= ldi_pkg::ST_ADDR; // [R06]
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_seen) begin
      state <= ldi_pkg::ST_IDLE; // [R06]
      sda_oe <= 1'b0;
    end else begin
      case (state)
        ldi_pkg::ST_ADDR, ldi_pkg::ST_REG, ldi_pkg::ST_WDATA: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s}; // [R04]
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_end) begin
            bit_cnt <= 4'h0;
            if (state == ldi_pkg::ST_ADDR) begin
              if (shreg[7:1] == own_addr) begin
                sda_oe <= 1'b1; // [R07]
                read_dir <= shreg[0]; // [R03]
                state <= ldi_pkg::ST_ADDR_ACK;
              end else begin
                state <= ldi_pkg::ST_IDLE;
              end
            end else begin
              sda_oe <= 1'b1; // [R09] [R10]
              state <= (state == ldi_pkg::ST_REG) ? ldi_pkg::ST_REG_ACK
                                                  : ldi_pkg::ST_WDATA_ACK;
            end
          end
        end
        ldi_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (read_dir) begin
              tx_byte <= rd_byte; // [R13]
              sda_oe <= ~rd_byte[7];
              state <= ldi_pkg::ST_READ;
            end else begin
              sda_oe <= 1'b0;
              state <= ldi_pkg::ST_REG;
            end
          end
        end
        ldi_pkg::ST_REG_ACK, ldi_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            state <= ldi_pkg::ST_WDATA;
          end
        end
        ldi_pkg::ST_READ: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_end) begin
            bit_cnt <= 4'h0;
            sda_oe <= 1'b0;
            state <= ldi_pkg::ST_READ_ACK;
          end else if (scl_fall) begin
            tx_byte <= {tx_byte[6:0], 1'b0};
            sda_oe <= ~tx_byte[6];
          end
        end
        ldi_pkg::ST_READ_ACK: begin
          if (scl_rise) begin
            master_ack <= ~sda_s;
          end else if (scl_fall) begin
            if (master_ack) begin
              tx_byte <= rd_byte;
              sda_oe <= ~rd_byte[7];
              state <= ldi_pkg::ST_READ;
            end else begin
              state <= ldi_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register pointer
  // ----------------------------------------------------------------------
  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      reg_ptr <= ldi_pkg::PTR_RESET;
    end else if (byte_end && state == ldi_pkg::ST_REG) begin
      reg_ptr <= shreg; // [R09]
    end else if (data_taken
        || (scl_rise && state == ldi_pkg::ST_READ_ACK && !sda_s)) begin
      reg_ptr <= reg_ptr + 8'h01; // [R11]
    end
  end

  assign page_rd_addr = reg_ptr;
  assign page_rd_page = page;

  // ----------------------------------------------------------------------
  // Read selection
  // ----------------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    if (reg_ptr == ldi_pkg::REG_PAGE_SELECT_UNLOCK) begin
      rd_byte = unlock; // [R12]
    end else if (reg_ptr == ldi_pkg::REG_INTERRUPT_FLAGS) begin
      rd_byte = {3'h0, flags_l}; // [R12]
    end else if ((page == ldi_pkg::LED_CONTROL_PAGE
                  && reg_ptr >= ldi_pkg::LED_READ_FIRST
                  && reg_ptr <= ldi_pkg::LED_READ_LAST)
                 || (page == ldi_pkg::FUNCTION_PAGE
                     && reg_ptr == ldi_pkg::FUNCTION_READ_ADDR)) begin
      rd_byte = page_rd_data; // [R12] [R14]
    end
  end

  // A flag register read clears the flags in the core domain.
  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      clear_tgl <= 1'b0;
    end else if (tx_load && reg_ptr == ldi_pkg::REG_INTERRUPT_FLAGS) begin
      clear_tgl <= ~clear_tgl;
    end
  end

  // ----------------------------------------------------------------------
  // Lock, page and mask registers
  // ----------------------------------------------------------------------
  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      unlock <= ldi_pkg::UNLOCK_RESET; // [R18]
    end else if (data_taken) begin
      if (reg_ptr == ldi_pkg::REG_PAGE_SELECT_UNLOCK) begin
        unlock <= shreg; // [R18]
      end else if (reg_ptr == ldi_pkg::REG_PAGE_SELECT
                   && unlock == ldi_pkg::PAGE_UNLOCK_KEY) begin
        unlock <= ldi_pkg::UNLOCK_RESET; // [R18]
      end
    end
  end

  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      page <= ldi_pkg::PAGE_RESET; // [R15]
    end else if (data_taken && reg_ptr == ldi_pkg::REG_PAGE_SELECT
                 && unlock == ldi_pkg::PAGE_UNLOCK_KEY // [R17]
                 && shreg <= ldi_pkg::PAGE_LAST_VALUE) begin
      page <= shreg[1:0]; // [R15]
    end
  end

  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      mask_l <= ldi_pkg::MASK_RESET;
    end else if (data_taken
                 && reg_ptr == ldi_pkg::REG_INTERRUPT_ENABLE_MASK) begin
      mask_l <= shreg[3:0]; // [R20]
    end
  end

  // ----------------------------------------------------------------------
  // Paged write port
  // ----------------------------------------------------------------------
  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      page_wr_valid <= 1'b0;
      page_wr <= '0;
    end else begin
      page_wr_valid <= data_taken
        && reg_ptr != ldi_pkg::REG_INTERRUPT_ENABLE_MASK
        && reg_ptr != ldi_pkg::REG_INTERRUPT_FLAGS
        && reg_ptr != ldi_pkg::REG_PAGE_SELECT
        && reg_ptr != ldi_pkg::REG_PAGE_SELECT_UNLOCK;
      if (data_taken) begin
        page_wr.page <= page; // [R16]
        page_wr.addr <= reg_ptr;
        page_wr.data <= shreg;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Core domain: flags and interrupt
  // ----------------------------------------------------------------------
  localparam int CNT_W = $clog2(SELF_CLEAR_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SELF_CLEAR_CYCLES);

  logic [4:0] to_core, flags, enabled;
  logic clear_seen_d, read_clear, auto_clear;
  logic [3:0] mask_c;
  logic [CNT_W-1:0] low_cnt;

  ldi_sync #(.WIDTH(5)) u_core_sync (
    .clock(clock),
    .reset(reset),
    .async_in({clear_tgl, mask_l}),
    .sync_out(to_core)
  );

  ldi_sync #(.WIDTH(5)) u_link_sync (
    .clock(link_clock),
    .reset(link_reset),
    .async_in(flags),
    .sync_out(flags_l)
  );

  assign mask_c = to_core[3:0];
  assign read_clear = to_core[4] ^ clear_seen_d;
  assign auto_clear = mask_c[ldi_pkg::MASK_IRQ_SELF_CLEAR_EN]
                      && low_cnt == CNT_LAST; // [R19]
  assign enabled = flags & {{3{mask_c[ldi_pkg::MASK_BREATH_DONE_IRQ_EN]}},
                            mask_c[ldi_pkg::MASK_SHORT_IRQ_EN],
                            mask_c[ldi_pkg::MASK_OPEN_IRQ_EN]}; // [R20]

  always_ff @(posedge clock) begin
    if (reset) begin
      clear_seen_d <= 1'b0;
    end else begin
      clear_seen_d <= to_core[4];
    end
  end

  // New events win over a clear in the same cycle.
  always_ff @(posedge clock) begin
    if (reset) begin
      flags <= ldi_pkg::FLAGS_RESET; // [R21]
    end else begin
      flags <= (flags & ~{5{read_clear | auto_clear}}) | events; // [R21]
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= ~(|enabled); // [R22]
    end
  end

  always_ff @(posedge clock) begin
    if (reset || irq_out_n
        || !mask_c[ldi_pkg::MASK_IRQ_SELF_CLEAR_EN]) begin
      low_cnt <= '0;
    end else if (low_cnt != CNT_LAST) begin
      low_cnt <= low_cnt + CNT_W'(1); // [R19]
    end
  end

endmodule : ldi_i2c_port

// ===== verification/ldi_i2c_port_chk.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------
module ldi_i2c_port_chk (
  input wire logic clock, // Core clock.
  input wire logic reset, // Reset, high.
  input wire logic link_clock, // Link clock.
  input wire logic scl, // Serial clock.
  input wire logic sda_in, // Data level.
  input wire logic sda_out, // Data drive value.
  input wire logic sda_oe, // Data drive enable.
  input wire logic addr_strap_low_pair, // Strap, low pair.
  input wire logic addr_strap_high_pair, // Strap, high pair.
  input wire ldi_pkg::ldi_flags_s events, // Flag set inputs.
  input wire logic irq_out_n, // Interrupt.
  input wire logic page_wr_valid, // Paged write pulse.
  input wire ldi_pkg::ldi_page_wr_s page_wr, // Paged write.
  input wire logic [1:0] page_rd_page, // Page.
  input wire logic [7:0] page_rd_addr, // Pointer.
  input wire logic [7:0] page_rd_data // Read data.
);
  logic ev_seen;
  always_ff @(posedge clock) begin
    if (reset) begin
      ev_seen <= 1'b0;
    end else if (|events) begin
      ev_seen <= 1'b1;
    end
  end
  chk_irq_reset: assert property (@(posedge clock) reset |=> irq_out_n)
    else $error("interrupt low after reset");
  chk_link_reset: assert property (@(posedge link_clock) reset [*4] |=>
    !sda_oe && !page_wr_valid && page_rd_page == 2'h0 && page_wr == '0)
    else $error("link outputs not at reset value");
  chk_oe_scl_low: assert property (
    @(posedge link_clock) disable iff (reset) $changed(sda_oe) |-> !scl)
    else $error("drive moved with clock high");
  chk_open_drain: assert property (
    @(posedge link_clock) disable iff (reset) !sda_out)
    else $error("data driven high");
  chk_wr_pulse: assert property (
    @(posedge link_clock) disable iff (reset) page_wr_valid |=> !page_wr_valid)
    else $error("write pulse too long");
  chk_wr_page: assert property (
    @(posedge link_clock) disable iff (reset)
    page_wr_valid |-> page_wr.page == page_rd_page)
    else $error("write on wrong page");
  chk_wr_global: assert property (
    @(posedge link_clock) disable iff (reset)
    page_wr_valid |-> !(page_wr.addr inside {8'hF0, 8'hF1, 8'hFD, 8'hFE}))
    else $error("global register paged");
  chk_page_move: assert property (
    @(posedge link_clock) disable iff (reset) $changed(page_rd_page) |-> !scl)
    else $error("page moved outside write");
  chk_irq_cause: assert property (@(posedge clock) disable iff (reset)
    !irq_out_n |-> ev_seen) else $error("interrupt without event");
endmodule : ldi_i2c_port_chk

bind ldi_i2c_port ldi_i2c_port_chk chk_i (
  .clock(clock), .reset(reset), .link_clock(link_clock), .scl(scl),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .addr_strap_low_pair(addr_strap_low_pair),
  .addr_strap_high_pair(addr_strap_high_pair), .events(events),
  .irq_out_n(irq_out_n), .page_wr_valid(page_wr_valid), .page_wr(page_wr),
  .page_rd_page(page_rd_page), .page_rd_addr(page_rd_addr),
  .page_rd_data(page_rd_data));

// ===== verification/ldi_ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Bus controller model
// ----------------------------------------------------------------------
module ldi_ctrl_model (
  input wire logic sda_line, // Resolved data level.
  output logic scl, // Serial clock drive.
  output logic sda_pull // High pulls data low.
);
  localparam int Q = 125;
  logic [8:0] res; // Last byte and its acknowledge bit.
  event got;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic bit_io(input logic b, output logic s);
    scl = 1'b0;
    #Q sda_pull = ~b;
    #Q scl = 1'b1;
    #Q s = sda_line;
    #Q;
  endtask : bit_io
  task automatic start();
    scl = 1'b0;
    #Q sda_pull = 1'b0;
    #Q scl = 1'b1;
    #(2 * Q) sda_pull = 1'b1;
    #(2 * Q);
  endtask : start
  task automatic stop();
    scl = 1'b0;
    #Q sda_pull = 1'b1;
    #Q scl = 1'b1;
    #(2 * Q) sda_pull = 1'b0;
    #(2 * Q);
  endtask : stop
  task automatic send(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    res = {d, s};
    ->got;
  endtask : send
  task automatic recv(input logic nack);
    logic [7:0] r;
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, r[i]);
    bit_io(nack, s);
    res = {r, nack};
    ->got;
  endtask : recv
endmodule : ldi_ctrl_model

// ===== verification/ldi_i2c_port_bench.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------
module ldi_i2c_port_bench;
  localparam int SC = 20;
  logic clock = 1'b0;
  logic link_clock = 1'b0;
  logic reset = 1'b1;
  ldi_pkg::ldi_flags_s events = '0;
  logic [7:0] page_rd_data = 8'h00;
  logic [1:0] lo_mode = 2'h0;
  logic [1:0] hi_mode = 2'h2;
  logic scl, sda_pull, sda_out, sda_oe, sda_line, irq_out_n, page_wr_valid;
  logic addr_strap_low_pair, addr_strap_high_pair;
  ldi_pkg::ldi_page_wr_s page_wr;
  logic [1:0] page_rd_page;
  logic [7:0] page_rd_addr;
  logic [1:0] page = 2'h0;
  logic [7:0] key = 8'h00;
  logic [8:0] exp_res[$];
  logic [17:0] exp_wr[$];
  int checks = 0;
  int miscompares = 0;
  integer seed = 85245;
  always #12.5 clock = ~clock;
  initial begin
    #3.1;
    forever #7.5 link_clock = ~link_clock;
  end
  assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));
  assign addr_strap_low_pair = lo_mode == 2'h0 ? 1'b0 : lo_mode == 2'h1 ? scl :
    lo_mode == 2'h2 ? sda_line : 1'b1;
  assign addr_strap_high_pair = hi_mode == 2'h0 ? 1'b0 : hi_mode == 2'h1 ? scl :
    hi_mode == 2'h2 ? sda_line : 1'b1;
  always @(posedge link_clock) page_rd_data <= #1 page_rd_addr ^ 8'h5A;
  ldi_ctrl_model ctrl (.sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));
  ldi_i2c_port #(.SELF_CLEAR_CYCLES(SC)) DUT (
    .clock(clock), .reset(reset), .link_clock(link_clock), .scl(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_low_pair(addr_strap_low_pair),
    .addr_strap_high_pair(addr_strap_high_pair), .events(events),
    .irq_out_n(irq_out_n), .page_wr_valid(page_wr_valid), .page_wr(page_wr),
    .page_rd_page(page_rd_page), .page_rd_addr(page_rd_addr),
    .page_rd_data(page_rd_data));
  task automatic summarize();
    $display("counts: %0d checks, %0d miscompares", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [17:0] got, input logic [17:0] want);
    checks++;
    if (got !== want) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk
  always @(ctrl.got) chk(18'(ctrl.res), 18'(exp_res.pop_front()));
  always @(posedge link_clock) begin
    if (page_wr_valid === 1'b1) chk(page_wr, exp_wr.pop_front());
  end
  function automatic logic [7:0] dev(input logic rw);
    return {ldi_pkg::TARGET_ADDR_FIXED, hi_mode, lo_mode, rw};
  endfunction : dev
  function automatic logic ok(input logic [7:0] a);
    return (page == 2'h0 && a >= 8'h18 && a <= 8'h47) ||
      (page == 2'h3 && a == 8'h11);
  endfunction : ok
  task automatic put(input logic [7:0] b, input logic nack);
    exp_res.push_back({b, nack});
    ctrl.send(b);
  endtask : put
  task automatic wr(input logic [7:0] ra, input logic [7:0] db[$]);
    logic [7:0] p;
    p = ra;
    ctrl.start();
    put(dev(1'b0), 1'b0);
    put(ra, 1'b0);
    foreach (db[i]) begin
      if (p == 8'hFE) key = db[i];
      else if (p == 8'hFD && key == 8'hC5) begin
        if (db[i] <= 8'h03) page = db[i][1:0];
        key = 8'h00;
      end else if (p != 8'hF0 && p != 8'hF1 && p != 8'hFD)
        exp_wr.push_back({page, p, db[i]});
      put(db[i], 1'b0);
      p++;
    end
    ctrl.stop();
  endtask : wr
  task automatic rd(input logic [7:0] ra, input int n, input logic [7:0] fl);
    logic [7:0] p, e;
    p = ra;
    ctrl.start();
    put(dev(1'b0), 1'b0);
    put(ra, 1'b0);
    ctrl.start();
    put(dev(1'b1), 1'b0);
    for (int i = 0; i < n; i++) begin
      e = p == 8'hFE ? key : p == 8'hF1 ? fl : ok(p) ? p ^ 8'h5A : 8'h00;
      exp_res.push_back({e, i == n - 1});
      ctrl.recv(i == n - 1);
      p++;
    end
    ctrl.stop();
  endtask : rd
  task automatic pulse(input logic [4:0] v);
    @(posedge clock);
    #1 events = v;
    @(posedge clock);
    #1 events = '0;
    repeat (4) @(posedge clock);
  endtask : pulse
  initial begin
    #2_000_000;
    miscompares++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge clock);
    #1 reset = 1'b0;
    repeat (10) @(posedge clock);
    chk(18'(irq_out_n), 18'h1);
    rd(8'hF1, 1, 8'h00);
    rd(8'hFE, 1, 8'h00);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      lo_mode = 2'(m);
      hi_mode = 2'(3 - m);
      wr(8'h10, '{8'($random(seed))});
    end
    ctrl.start();
    put({3'h4, hi_mode, lo_mode, 1'b0}, 1'b1);
    ctrl.stop();
    $display("test address done");
    wr(8'hFD, '{8'h03});
    chk(18'(page_rd_page), 18'h0);
    wr(8'hFE, '{8'hC5});
    rd(8'hFE, 1, 8'h00);
    wr(8'hFD, '{8'h03});
    rd(8'hFE, 1, 8'h00);
    wr(8'hFD, '{8'h01});
    wr(8'hFE, '{8'hC5});
    wr(8'hFD, '{8'h07});
    chk(18'(page_rd_page), 18'h3);
    wr(8'h20, '{8'($random(seed)), 8'($random(seed)), 8'h5E});
    $display("test page done");
    rd(8'h11, 2, 8'h00);
    rd(8'hFD, 1, 8'h00);
    wr(8'hFE, '{8'hC5});
    wr(8'hFD, '{8'h00});
    rd(8'h17, 3, 8'h00);
    wr(8'hFF, '{8'h5C, 8'hA3});
    $display("test read done");
    wr(8'hF0, '{8'h02});
    pulse(5'h01);
    chk(18'(irq_out_n), 18'h1);
    pulse(5'h02);
    chk(18'(irq_out_n), 18'h0);
    rd(8'hF1, 1, 8'h03);
    repeat (12) @(posedge clock);
    chk(18'(irq_out_n), 18'h1);
    wr(8'hF0, '{8'h0C});
    pulse(5'h08);
    chk(18'(irq_out_n), 18'h0);
    repeat (SC) @(posedge clock);
    chk(18'(irq_out_n), 18'h1);
    wr(8'hF0, '{8'h04});
    pulse(5'h10);
    repeat (2 * SC) @(posedge clock);
    chk(18'(irq_out_n), 18'h0);
    rd(8'hF1, 1, 8'h10);
    chk(18'(exp_wr.size()), 18'h0);
    $display("test interrupt done");
    summarize();
  end
endmodule : ldi_i2c_port_bench
